/* common/slgc_if.sv */
// Link between the strap latch top and its pin bank
interface slgc_if #(parameter int NCORE = slgc_pkg::SLGC_CORES);
  import slgc_pkg::*;
  localparam int CW = (NCORE > 1) ? $clog2(NCORE) : 1;
  logic [SLGC_PINS-1:0] pin_in;
  logic release_pins;
  logic clear;
  logic cfg_wr;
  slgc_cfg_type cfg_sel;
  logic [CW-1:0] cfg_core;
  logic [SLGC_PINS-1:0] cfg_data;
  logic [SLGC_PINS-1:0] dir;
  logic [SLGC_PINS-1:0] out;
  logic [SLGC_PINS-1:0] dma;
  logic [NCORE-1:0] irq;

  modport top (
    output pin_in, release_pins, clear, cfg_wr, cfg_sel, cfg_core,
    output cfg_data,
    input dir, out, dma, irq
  );
  modport bank (
    input pin_in, release_pins, clear, cfg_wr, cfg_sel, cfg_core,
    input cfg_data,
    output dir, out, dma, irq
  );
endinterface

/* common/slgc_pkg.sv */
// Shared constants and types for the strap latch and pin configuration block
package slgc_pkg;

  localparam int SLGC_PINS = 16;
  localparam int SLGC_CORES = 4;
  localparam int SLGC_PERIPHS = 8;
  localparam int SLGC_CLK_MHZ = 200;
  localparam int SLGC_INIT_TIME_NS = 100;
  localparam int SLGC_INIT_CYCLES =
    (SLGC_INIT_TIME_NS * SLGC_CLK_MHZ + 999) / 1000;

  // Strap field positions within the captured pin word
  localparam int SLGC_ORDER_BIT = 0;
  localparam int SLGC_BOOT_LO = 1;
  localparam int SLGC_BOOT_W = 3;
  localparam int SLGC_DCFG_LO = 4;
  localparam int SLGC_DCFG_W = 7;
  localparam int SLGC_PLL_LO = 11;
  localparam int SLGC_PLL_W = 3;
  localparam int SLGC_PCIE_LO = 14;
  localparam int SLGC_PCIE_W = 2;
  localparam int SLGC_VCID_LO = 4;
  localparam int SLGC_VCID_W = 2;

  // Pins kept for the voltage class function after release
  localparam logic [SLGC_PINS-1:0] SLGC_VCID_MASK = 16'h0030;
  localparam logic [SLGC_PINS-1:0] SLGC_PIN_ZERO = 16'h0000;

  typedef enum logic [2:0] {
    BOOT_NONE, BOOT_SRIO, BOOT_ETH, BOOT_PCIE,
    BOOT_I2C, BOOT_SPI, BOOT_CHIPLINK, BOOT_RSVD
  } slgc_boot_type;

  typedef enum logic [1:0] {
    PCIE_EP, PCIE_LEGACY_EP, PCIE_RC, PCIE_RSVD
  } slgc_pcie_type;

  typedef enum logic [2:0] {
    CFG_DIR, CFG_OUT, CFG_RISE, CFG_FALL, CFG_MASK, CFG_PERIPH
  } slgc_cfg_type;

  typedef enum logic [1:0] {RS_RESET, RS_INIT, RS_RUN} slgc_rst_type;

  // Boot device code to one-hot peripheral enable
  function automatic logic [SLGC_PERIPHS-1:0] slgc_boot_periph(
    input slgc_boot_type code);
    logic [SLGC_PERIPHS-1:0] en;
    en = '0;
    if (code != BOOT_NONE && code != BOOT_RSVD) begin
      en[code] = 1'b1;
    end
    return en;
  endfunction

endpackage

/* core/slgc_gpio_bank.sv */
// General purpose pin bank: direction, output data and edge events
module slgc_gpio_bank
  import slgc_pkg::*;
#(
  parameter int NCORE = SLGC_CORES
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  slgc_if.bank bus
);

  typedef struct packed {
    logic [SLGC_PINS-1:0] dir;
    logic [SLGC_PINS-1:0] out;
    logic [SLGC_PINS-1:0] rise;
    logic [SLGC_PINS-1:0] fall;
    logic [SLGC_PINS-1:0] prev;
    logic [NCORE-1:0][SLGC_PINS-1:0] mask;
    logic [SLGC_PINS-1:0] dma;
    logic [NCORE-1:0] irq;
  } slgc_bank_type;

  slgc_bank_type q, d;
  logic [SLGC_PINS-1:0] ev;

  always_comb begin
    d = q;
    d.prev = bus.pin_in;
    if (bus.clear) begin
      // Every pin comes back as an input with events off
      d.dir = SLGC_PIN_ZERO;
      d.out = SLGC_PIN_ZERO;
      d.rise = SLGC_PIN_ZERO;
      d.fall = SLGC_PIN_ZERO;
      d.mask = '0;
    end else if (bus.cfg_wr) begin
      unique case (bus.cfg_sel)
        CFG_DIR: d.dir = bus.cfg_data;
        CFG_OUT: d.out = bus.cfg_data;
        CFG_RISE: d.rise = bus.cfg_data;
        CFG_FALL: d.fall = bus.cfg_data;
        CFG_MASK: d.mask[bus.cfg_core] = bus.cfg_data;
        CFG_PERIPH: d.out = q.out;
        default: d.out = q.out;
      endcase
    end
    // Any usable pin raises an event on a chosen edge
    ev = ((bus.pin_in & ~q.prev & q.rise) |
          (~bus.pin_in & q.prev & q.fall)) &
         ~SLGC_VCID_MASK & {SLGC_PINS{bus.release_pins}};
    d.dma = ev;
    for (int c = 0; c < NCORE; c++) begin
      d.irq[c] = |(ev & q.mask[c]);
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bus.dir = q.dir & ~SLGC_VCID_MASK;
  assign bus.out = q.out;
  assign bus.dma = q.dma;
  assign bus.irq = q.irq;

endmodule

/* core/slgc_top.sv */
// Strap latch and general purpose pin configuration top level
module slgc_top
  import slgc_pkg::*;
#(
  parameter int NCORE = SLGC_CORES,
  parameter int PERIPHS = SLGC_PERIPHS,
  parameter int INIT_CYCLES = SLGC_INIT_CYCLES,
  localparam int CW = (NCORE > 1) ? $clog2(NCORE) : 1,
  localparam int CNT_W = $clog2(INIT_CYCLES + 1)
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic full_config_reset_n_i,
  input wire logic warm_reset_n_i,
  input wire logic emu_reset_req_i,
  input wire logic emu_halt_req_i,
  input wire logic [SLGC_PINS-1:0] gpio_in_i,
  output logic [SLGC_PINS-1:0] gpio_out_o,
  output logic [SLGC_PINS-1:0] gpio_oe_o,
  output logic [SLGC_PINS-1:0] gpio_value_o,
  input wire logic cfg_wr_i,
  input wire slgc_cfg_type cfg_sel_i,
  input wire logic [CW-1:0] cfg_core_i,
  input wire logic [SLGC_PINS-1:0] cfg_data_i,
  output logic [NCORE-1:0] gpio_irq_o,
  output logic [SLGC_PINS-1:0] dma_event_trigger_o,
  output logic reset_state_out_n_o,
  output logic strap_valid_o,
  output logic strap_capture_o,
  output logic [SLGC_PINS-1:0] strap_status_o,
  output logic byte_order_strap_o,
  output slgc_boot_type boot_device_o,
  output logic [SLGC_DCFG_W-1:0] device_cfg_o,
  output logic [SLGC_PLL_W-1:0] pll_mult_o,
  output logic [SLGC_PLL_W-1:0] i2c_boot_param_o,
  output slgc_pcie_type pcie_role_strap_o,
  output logic pcie_root_complex_o,
  output logic [SLGC_VCID_W-1:0] voltage_class_id_o,
  output logic [PERIPHS-1:0] periph_en_o,
  output logic emu_halt_o
);

  typedef struct packed {
    logic fcr_prev;
    logic valid;
    logic capture;
    logic [SLGC_PINS-1:0] straps;
    logic [SLGC_PINS-1:0] value;
    logic byte_order;
    slgc_boot_type boot;
    logic [SLGC_DCFG_W-1:0] dev_cfg;
    logic [SLGC_PLL_W-1:0] pll;
    logic [SLGC_PLL_W-1:0] i2c;
    slgc_pcie_type pcie;
    logic pcie_rc;
    logic [SLGC_VCID_W-1:0] vcid;
    logic [PERIPHS-1:0] boot_en;
    logic [PERIPHS-1:0] sw_en;
    logic [PERIPHS-1:0] periph;
    slgc_rst_type rs;
    logic [CNT_W-1:0] cnt;
    logic rs_n;
    logic emu_halt;
  } slgc_top_type;

  // One register image of the top level state; the pin bank keeps its own registers
  slgc_top_type q, d;
  logic any_rst;
  logic release_edge;
  logic [SLGC_PLL_W-1:0] pll_field;
  slgc_boot_type boot_code;
  logic [SLGC_PERIPHS-1:0] boot_onehot;

  // Carrier to the pin bank
  slgc_if #(.NCORE(NCORE)) pins ();

  always_comb begin
    d = q;
    // Emulator request resets the device whatever the boot straps say
    any_rst = !full_config_reset_n_i || !warm_reset_n_i || emu_reset_req_i;
    release_edge = full_config_reset_n_i && !q.fcr_prev;
    pll_field = gpio_in_i[SLGC_PLL_LO +: SLGC_PLL_W];
    boot_code = slgc_boot_type'(
      gpio_in_i[SLGC_BOOT_LO +: SLGC_BOOT_W]);
    // Boot interface one-hot, sized to the peripheral count
    boot_onehot = slgc_boot_periph(boot_code);
    d.fcr_prev = full_config_reset_n_i;
    d.capture = release_edge;

    // Only the rising full reset samples the pins; warm reset does not
    if (release_edge) begin
      d.straps = gpio_in_i;
      d.valid = 1'b1;
      d.byte_order = gpio_in_i[SLGC_ORDER_BIT];
      d.boot = boot_code;
      d.dev_cfg = gpio_in_i[SLGC_DCFG_LO +: SLGC_DCFG_W];
      if (d.boot == BOOT_I2C) begin
        d.i2c = pll_field;
        d.pll = '0;
      end else begin
        d.pll = pll_field;
        d.i2c = '0;
      end
      d.pcie = slgc_pcie_type'(
        gpio_in_i[SLGC_PCIE_LO +: SLGC_PCIE_W]);
      d.pcie_rc = (d.pcie == PCIE_RC);
      d.boot_en = PERIPHS'(boot_onehot);
    end

    // Pins 4 and 5 report the voltage class once released
    if (full_config_reset_n_i) begin
      d.vcid = gpio_in_i[SLGC_VCID_LO +: SLGC_VCID_W];
      d.value = gpio_in_i & ~SLGC_VCID_MASK;
    end else begin
      d.value = SLGC_PIN_ZERO;
    end

    // Software enables, cleared by every reset
    if (any_rst) begin
      d.sw_en = '0;
    end else if (cfg_wr_i && cfg_sel_i == CFG_PERIPH) begin
      d.sw_en = cfg_data_i[PERIPHS-1:0];
    end
    if (any_rst) begin
      d.periph = '0;
    end else begin
      d.periph = d.sw_en | q.boot_en;
    end

    // Reset state output stays low through initialisation
    unique case (q.rs)
      RS_RESET: begin
        d.rs = RS_INIT;
        d.cnt = CNT_W'(INIT_CYCLES - 1);
      end
      RS_INIT: begin
        if (q.cnt == '0) begin
          d.rs = RS_RUN;
        end else begin
          d.cnt = q.cnt - CNT_W'(1);
        end
      end
      RS_RUN: d.rs = RS_RUN;
      default: d.rs = RS_RESET;
    endcase
    if (any_rst) begin
      d.rs = RS_RESET;
      d.cnt = '0;
    end
    d.rs_n = (d.rs == RS_RUN);

    // Halt request is honoured in every boot mode
    d.emu_halt = emu_halt_req_i;
  end

  // State register, cleared only by power-on reset
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Pin bank sees raw levels and the shared write strobe
  assign pins.pin_in = gpio_in_i;
  assign pins.release_pins = full_config_reset_n_i;
  assign pins.clear = any_rst;
  assign pins.cfg_wr = cfg_wr_i;
  assign pins.cfg_sel = cfg_sel_i;
  assign pins.cfg_core = cfg_core_i;
  assign pins.cfg_data = cfg_data_i;

  // Direction, output data and pin events live in the bank
  slgc_gpio_bank #(.NCORE(NCORE)) u_bank (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .bus(pins.bank)
  );

  // Drivers only follow direction once full reset is high
  assign gpio_oe_o = pins.dir & {SLGC_PINS{full_config_reset_n_i}};
  assign gpio_out_o = pins.out;
  assign gpio_value_o = q.value;
  assign gpio_irq_o = pins.irq;
  assign dma_event_trigger_o = pins.dma;
  assign reset_state_out_n_o = q.rs_n;
  assign strap_valid_o = q.valid;
  assign strap_capture_o = q.capture;
  assign strap_status_o = q.straps;
  assign byte_order_strap_o = q.byte_order;
  assign boot_device_o = q.boot;
  assign device_cfg_o = q.dev_cfg;
  assign pll_mult_o = q.pll;
  assign i2c_boot_param_o = q.i2c;
  assign pcie_role_strap_o = q.pcie;
  assign pcie_root_complex_o = q.pcie_rc;
  assign voltage_class_id_o = q.vcid;
  assign periph_en_o = q.periph;
  assign emu_halt_o = q.emu_halt;

endmodule

/* tb/slgc_board.sv */
// Board strap drivers that release the pins once reset state rises
module slgc_board
  import slgc_pkg::*;
(
  input wire logic rst_state_n_i,
  input wire logic [SLGC_PINS-1:0] strap_i,
  input wire logic [SLGC_PINS-1:0] user_i,
  input wire logic [SLGC_PINS-1:0] out_i,
  input wire logic [SLGC_PINS-1:0] oe_i,
  output logic [SLGC_PINS-1:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Straps held until reset state rises, then user_i levels driven
  assign pin_o = (oe_i & out_i) |
                 (~oe_i & (rst_state_n_i ? user_i : strap_i));
endmodule

/* tb/slgc_top_props.sv */
// Port checker for the strap latch top
module slgc_top_props
  import slgc_pkg::*;
#(
  parameter int PERIPHS = SLGC_PERIPHS
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic full_config_reset_n_i,
  input wire logic warm_reset_n_i,
  input wire logic emu_reset_req_i,
  input wire logic emu_halt_req_i,
  input wire logic [SLGC_PINS-1:0] gpio_in_i,
  input wire logic [SLGC_PINS-1:0] gpio_oe_o,
  input wire logic [SLGC_PINS-1:0] dma_event_trigger_o,
  input wire logic strap_capture_o,
  input wire logic [SLGC_PINS-1:0] strap_status_o,
  input wire logic byte_order_strap_o,
  input wire slgc_boot_type boot_device_o,
  input wire logic [SLGC_DCFG_W-1:0] device_cfg_o,
  input wire logic [SLGC_PLL_W-1:0] pll_mult_o,
  input wire logic [SLGC_PLL_W-1:0] i2c_boot_param_o,
  input wire slgc_pcie_type pcie_role_strap_o,
  input wire logic pcie_root_complex_o,
  input wire logic [PERIPHS-1:0] periph_en_o,
  input wire logic emu_halt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  a_oe_off_reset: assert property (
    !full_config_reset_n_i |-> gpio_oe_o == '0)
    else $error("pin driver on in full reset");
  a_capture_on_rise: assert property (
    $rose(full_config_reset_n_i) |=> strap_capture_o)
    else $error("no capture pulse");
  a_capture_pins: assert property (
    strap_capture_o |-> strap_status_o == $past(gpio_in_i))
    else $error("captured word wrong");
  a_status_held: assert property (
    !$stable(strap_status_o) |-> strap_capture_o)
    else $error("status changed without capture");
  a_order_boot: assert property (
    byte_order_strap_o == strap_status_o[0] &&
    boot_device_o == strap_status_o[3:1])
    else $error("order or boot decode wrong");
  a_dev_cfg: assert property (
    device_cfg_o == strap_status_o[10:4])
    else $error("device options wrong");
  a_pll_or_i2c: assert property (
    boot_device_o == BOOT_I2C ?
    (i2c_boot_param_o == strap_status_o[13:11] && pll_mult_o == '0) :
    (pll_mult_o == strap_status_o[13:11] && i2c_boot_param_o == '0))
    else $error("pll or i2c decode wrong");
  a_pcie_role: assert property (
    pcie_role_strap_o == strap_status_o[15:14] &&
    pcie_root_complex_o == (strap_status_o[15:14] == 2'h2))
    else $error("pcie role wrong");
  a_vcid_quiet: assert property (
    gpio_oe_o[5:4] == 2'h0 && dma_event_trigger_o[5:4] == 2'h0)
    else $error("voltage class pin active");
  a_periph_reset: assert property (
    (!warm_reset_n_i || emu_reset_req_i) |=> periph_en_o == '0)
    else $error("peripheral enabled in reset");
  a_halt_follow: assert property (
    emu_halt_o == $past(emu_halt_req_i))
    else $error("halt not delayed one cycle");
endmodule
bind slgc_top slgc_top_props #(.PERIPHS(PERIPHS)) u_props (.clk_i, .nrst_i,
  .full_config_reset_n_i, .warm_reset_n_i, .emu_reset_req_i, .emu_halt_req_i,
  .gpio_in_i, .gpio_oe_o, .dma_event_trigger_o, .strap_capture_o,
  .strap_status_o, .byte_order_strap_o, .boot_device_o, .device_cfg_o,
  .pll_mult_o, .i2c_boot_param_o, .pcie_role_strap_o, .pcie_root_complex_o,
  .periph_en_o, .emu_halt_o);

/* tb/tb.sv */
// Self-checking bench for the strap latch top
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import slgc_pkg::*;
  logic clk_i = 0, nrst_i = 0, fcr = 0, warm = 1, emu_rst = 0, emu_halt = 0;
  logic cfg_wr = 0, rs_n, cap, halt, valid;
  slgc_cfg_type cfg_sel = CFG_DIR;
  logic [1:0] cfg_core = 0;
  logic [15:0] cfg_data = 0, strap = 0, user = 0, pins, g_out, g_oe, dma;
  logic [15:0] status, s, e, old, val, pe;
  logic [1:0] vcid;
  logic [7:0] periph;
  logic [3:0] irq;
  logic [31:0] rng = 39;
  logic [15:0] sq[$], dq[$], iq[$];
  int bad_count = 0, n_checks = 0;
  slgc_top #(.INIT_CYCLES(3)) uut (.clk_i, .nrst_i,
    .full_config_reset_n_i(fcr), .warm_reset_n_i(warm),
    .emu_reset_req_i(emu_rst), .emu_halt_req_i(emu_halt), .gpio_in_i(pins),
    .gpio_out_o(g_out), .gpio_oe_o(g_oe), .gpio_value_o(val),
    .cfg_wr_i(cfg_wr),
    .cfg_sel_i(cfg_sel), .cfg_core_i(cfg_core), .cfg_data_i(cfg_data),
    .gpio_irq_o(irq), .dma_event_trigger_o(dma), .reset_state_out_n_o(rs_n),
    .strap_valid_o(valid), .strap_capture_o(cap), .strap_status_o(status),
    .byte_order_strap_o(), .boot_device_o(), .device_cfg_o(), .pll_mult_o(),
    .i2c_boot_param_o(), .pcie_role_strap_o(), .pcie_root_complex_o(),
    .voltage_class_id_o(vcid), .periph_en_o(periph), .emu_halt_o(halt));
  slgc_board brd (.rst_state_n_i(rs_n), .strap_i(strap), .user_i(user),
    .out_i(g_out), .oe_i(g_oe), .pin_o(pins));
  initial forever #2.5 clk_i = ~clk_i;
  function automatic logic [31:0] xs(logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic chk(string nm, logic [15:0] ex, logic [15:0] got);
    n_checks++;
    if (ex !== got) begin
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
      bad_count++;
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wait_rs;
    int i;
    i = 0;
    while (rs_n !== 1'b1 && i < 100) begin
      @(posedge clk_i);
      i++;
    end
    if (rs_n !== 1'b1) begin
      bad_count++;
      stop_test;
    end
  endtask
  task automatic wr(slgc_cfg_type sl, logic [1:0] c, logic [15:0] d);
    cfg_sel <= sl;
    cfg_core <= c;
    cfg_data <= d;
    cfg_wr <= 1;
    @(posedge clk_i);
    cfg_wr <= 0;
    @(posedge clk_i);
  endtask
  task automatic boot(logic [15:0] v);
    fcr <= 0;
    strap <= v;
    wr(CFG_DIR, 0, 16'hFFFF);
    chk("oe_rst", 16'h0000, g_oe);
    fcr <= 1;
    sq.push_back(v);
    cyc(1);
    wait_rs;
  endtask
  // Monitor pops the oldest expected result as each one appears
  always @(posedge clk_i) begin
    if (nrst_i && cap) begin
      if (sq.size() == 0) chk("capture", 16'h0000, 16'h0001);
      else chk("status", sq.pop_front(), status);
    end
    if (nrst_i && dma !== 16'h0000) begin
      e = (dq.size() == 0) ? 16'h0000 : dq.pop_front();
      chk("dma", e, dma);
      e = (iq.size() == 0) ? 16'h0000 : iq.pop_front();
      chk("irq", e, {12'h000, irq});
    end
  end
  initial begin
    cyc(4);
    nrst_i <= 1;
    for (int c = 0; c < 8; c++) begin
      rng = xs(rng);
      s = {rng[15:4], 3'(c), rng[0]};
      boot(s);
      chk("oe_boot", 16'h0000, g_oe);
      chk("valid", 16'h0001, {15'h0, valid});
      pe = (c == 0 || c == 7) ? 16'h0 : 16'(1 << c);
      chk("periph", pe, {8'h0, periph});
      $display("test boot code %0d done", c);
    end
    wr(CFG_DIR, 0, 16'hFFFF);
    chk("oe_user", 16'hFFCF, g_oe);
    rng = xs(rng);
    wr(CFG_OUT, 0, rng[15:0]);
    cyc(1);
    chk("out", rng[15:0], g_out);
    chk("value", rng[15:0] & 16'hFFCF, val);
    wr(CFG_DIR, 0, 16'h0000);
    wr(CFG_RISE, 0, 16'hFFFF);
    wr(CFG_FALL, 0, 16'h0002);
    wr(CFG_MASK, 0, 16'hFFFF);
    wr(CFG_MASK, 2, 16'h0002);
    user <= 16'h0032;
    dq.push_back(16'h0002);
    iq.push_back(16'h0005);
    cyc(4);
    chk("vcid", 16'h0003, {14'h0, vcid});
    user <= 16'h0000;
    dq.push_back(16'h0002);
    iq.push_back(16'h0005);
    cyc(4);
    chk("dma_left", 16'h0000, 16'(dq.size() + iq.size()));
    $display("test events done");
    old = status;
    strap <= ~status;
    warm <= 0;
    cyc(3);
    warm <= 1;
    cyc(1);
    wait_rs;
    chk("warm_keep", old, status);
    emu_rst <= 1;
    emu_halt <= 1;
    cyc(3);
    chk("emu_periph", 16'h0000, {8'h0, periph});
    chk("halt", 16'h0001, {15'h0, halt});
    emu_rst <= 0;
    cyc(1);
    wait_rs;
    chk("emu_keep", old, status);
    wr(CFG_PERIPH, 0, 16'h0081);
    chk("periph_sw", 16'h0081, {8'h0, periph});
    $display("test resets done");
    stop_test;
  end
endmodule
